// [dmo_pkg.sv]
// Shared constants for the dual converter multiplexed output block
package dmo_pkg;

  localparam int unsigned SAMPLE_W       = 10;
  localparam int unsigned PIPE_STAGES    = 9;
  localparam int unsigned LATENCY_CYCLES = 5;
  localparam int unsigned ADDR_W         = 8;

  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;

  localparam int unsigned CTRL_FMT_TWOS_BIT  = 0;
  localparam int unsigned CTRL_SLEEP_BIT     = 1;
  localparam int unsigned CTRL_POWER_DOWN_BIT = 2;
  localparam int unsigned CTRL_OUT_DIS_N_BIT = 3;

  localparam int unsigned STAT_CHAN_IND_BIT  = 0;
  localparam int unsigned STAT_PRIMED_BIT    = 1;
  localparam int unsigned STAT_RUNNING_BIT   = 2;
  localparam int unsigned STAT_BUS_EN_BIT    = 3;

  localparam logic        CTRL_FMT_TWOS_RST  = 1'b0;
  localparam logic        CTRL_SLEEP_RST     = 1'b0;
  localparam logic        CTRL_POWER_DOWN_RST = 1'b0;
  localparam logic        CTRL_OUT_DIS_N_RST = 1'b1;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

endpackage

// [dmo_ctrl_if.sv]
// Control and status signals between register slave and converter core
`timescale 1ns/1ps
interface dmo_ctrl_if;
  logic fmt_twos;
  logic sleep;
  logic power_down_input;
  logic out_dis_n;
  logic chan_ind;
  logic primed;
  logic running;
  logic bus_en;

  modport reg_side (
    output fmt_twos,
    output sleep,
    output power_down_input,
    output out_dis_n,
    input  chan_ind,
    input  primed,
    input  running,
    input  bus_en
  );

  modport core_side (
    input  fmt_twos,
    input  sleep,
    input  power_down_input,
    input  out_dis_n,
    output chan_ind,
    output primed,
    output running,
    output bus_en
  );
endinterface

// [dmo_ahb_regs.sv]
// AHB-Lite register slave holding the static converter controls
`timescale 1ns/1ps
module dmo_ahb_regs
  import dmo_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata_q,
  output logic                   hreadyout_q,
  output logic                   hresp_q,
  dmo_ctrl_if.reg_side           ctrl
);

  logic              wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic              addr_ok;
  logic [31:0]       rd_word;

  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == 3'h2);

  always_comb begin
    rd_word = 32'h0000_0000;
    if (haddr == CTRL_OFFSET) begin
      rd_word[CTRL_FMT_TWOS_BIT]   = ctrl.fmt_twos;
      rd_word[CTRL_SLEEP_BIT]      = ctrl.sleep;
      rd_word[CTRL_POWER_DOWN_BIT] = ctrl.power_down_input;
      rd_word[CTRL_OUT_DIS_N_BIT]  = ctrl.out_dis_n;
    end else if (haddr == STATUS_OFFSET) begin
      rd_word[STAT_CHAN_IND_BIT] = ctrl.chan_ind;
      rd_word[STAT_PRIMED_BIT]   = ctrl.primed;
      rd_word[STAT_RUNNING_BIT]  = ctrl.running;
      rd_word[STAT_BUS_EN_BIT]   = ctrl.bus_en;
    end
  end

  // Read data captured at address phase, presented in data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata_q <= rd_word;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl.fmt_twos         <= CTRL_FMT_TWOS_RST;
      ctrl.sleep            <= CTRL_SLEEP_RST;
      ctrl.power_down_input <= CTRL_POWER_DOWN_RST;
      ctrl.out_dis_n        <= CTRL_OUT_DIS_N_RST;
    end else if (wr_pend_q && wr_addr_q == CTRL_OFFSET) begin
      ctrl.fmt_twos         <= hwdata[CTRL_FMT_TWOS_BIT];
      ctrl.sleep            <= hwdata[CTRL_SLEEP_BIT];
      ctrl.power_down_input <= hwdata[CTRL_POWER_DOWN_BIT];
      ctrl.out_dis_n        <= hwdata[CTRL_OUT_DIS_N_BIT];
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
  end

endmodule

// [dmo_core.sv]
// Dual converter sample pipeline with multiplexed three-state output
`timescale 1ns/1ps
module dmo_core
  import dmo_pkg::*;
#(
  parameter int unsigned STAGES = PIPE_STAGES
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                conv_clk,
  input  wire logic [SAMPLE_W-1:0] first_channel,
  input  wire logic [SAMPLE_W-1:0] second_channel,
  input  wire logic                hsel,
  input  wire logic [ADDR_W-1:0]   haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [SAMPLE_W-1:0]      shared_sample_bus_o,
  output logic                     shared_sample_bus_oe,
  output logic                     chan_ind
);

  localparam int unsigned DEPTH = STAGES + 1;
  localparam int unsigned MSB   = SAMPLE_W - 1;

  //////////////////////////////////////////////////////////////////////////////

  logic rst_sync1_q;
  logic rst_n;

  // Reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync1_q <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_n       <= rst_sync1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  dmo_ctrl_if ctrl ();

  logic [31:0] hrdata_w;
  logic        hreadyout_w;
  logic        hresp_w;

  dmo_ahb_regs u_regs (
    .clk         (clk),
    .rst_n       (rst_n),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .hwdata      (hwdata),
    .hready      (hready),
    .hrdata_q    (hrdata_w),
    .hreadyout_q (hreadyout_w),
    .hresp_q     (hresp_w),
    .ctrl        (ctrl.reg_side)
  );

  assign hrdata    = hrdata_w;
  assign hreadyout = hreadyout_w;
  assign hresp     = hresp_w;

  //////////////////////////////////////////////////////////////////////////////

  logic cclk_q;
  logic rise;
  logic fall;
  logic halted;
  logic running;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cclk_q <= 1'b0;
    end else begin
      cclk_q <= conv_clk;
    end
  end

  assign rise    = conv_clk && !cclk_q;
  assign fall    = !conv_clk && cclk_q;
  assign halted  = ctrl.power_down_input;
  assign running = !ctrl.sleep && !ctrl.power_down_input;

  //////////////////////////////////////////////////////////////////////////////

  logic [SAMPLE_W-1:0] pipe_a_q [DEPTH];
  logic [SAMPLE_W-1:0] pipe_b_q [DEPTH];
  logic [DEPTH-1:0]    pipe_v_q;
  logic [SAMPLE_W-1:0] hold_b_q;
  logic                hold_bv_q;

  // Entry 0 is the track-and-hold, then one stage per half cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe_v_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        pipe_a_q[i] <= '0;
        pipe_b_q[i] <= '0;
      end
    end else if (!running) begin
      pipe_v_q <= '0;
    end else if (rise || fall) begin
      pipe_a_q[0] <= first_channel;
      pipe_b_q[0] <= second_channel;
      pipe_v_q[0] <= rise;
      for (int i = 1; i < DEPTH; i++) begin
        pipe_a_q[i] <= pipe_a_q[i-1];
        pipe_b_q[i] <= pipe_b_q[i-1];
        pipe_v_q[i] <= pipe_v_q[i-1];
      end
    end
  end

  function automatic logic [SAMPLE_W-1:0] fmt(input logic [SAMPLE_W-1:0] raw,
                                              input logic twos);
    logic [SAMPLE_W-1:0] w;
    w      = raw;
    w[MSB] = raw[MSB] ^ twos;
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  logic [SAMPLE_W-1:0] bus_q;
  logic                oe_q;
  logic                ind_q;
  logic                primed_q;

  // Output latch: first channel on rise, second channel half a cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q     <= '0;
      hold_b_q  <= '0;
      hold_bv_q <= 1'b0;
    end else if (halted) begin
      bus_q     <= bus_q;
      hold_bv_q <= 1'b0;
    end else if (!running) begin
      hold_bv_q <= 1'b0;
    end else if (rise && pipe_v_q[STAGES]) begin
      bus_q     <= fmt(pipe_a_q[STAGES], ctrl.fmt_twos);
      hold_b_q  <= pipe_b_q[STAGES];
      hold_bv_q <= 1'b1;
    end else if (fall && hold_bv_q) begin
      bus_q     <= fmt(hold_b_q, ctrl.fmt_twos);
      hold_bv_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= !ctrl.out_dis_n;
    end
  end

  // Indicator frozen with the data during power-down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_q <= 1'b0;
    end else if (!halted && rise) begin
      ind_q <= 1'b1;
    end else if (!halted && fall) begin
      ind_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      primed_q <= 1'b0;
    end else if (!running) begin
      primed_q <= 1'b0;
    end else if (rise && pipe_v_q[STAGES]) begin
      primed_q <= 1'b1;
    end
  end

  assign shared_sample_bus_o  = bus_q;
  assign shared_sample_bus_oe = oe_q;
  assign chan_ind             = ind_q;

  assign ctrl.chan_ind = ind_q;
  assign ctrl.primed   = primed_q;
  assign ctrl.running  = running;
  assign ctrl.bus_en   = oe_q;

  //////////////////////////////////////////////////////////////////////////////

  logic [3:0] rise_cnt_q;

  // Counts rising edges since the pipeline was last flushed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt_q <= '0;
    end else if (!running) begin
      rise_cnt_q <= '0;
    end else if (rise && rise_cnt_q != 4'hF) begin
      rise_cnt_q <= rise_cnt_q + 4'h1;
    end
  end

  a_ind_rise: assert property (@(posedge clk) disable iff (!rst_n)
    (rise && !halted) |=> chan_ind)
    else $error("indicator not high after converter clock rise");

  a_ind_fall: assert property (@(posedge clk) disable iff (!rst_n)
    (fall && !halted) |=> !chan_ind)
    else $error("indicator not low after converter clock fall");

  a_oe_follow: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 (shared_sample_bus_oe == !$past(ctrl.out_dis_n)))
    else $error("bus enable does not follow output enable");

  a_chan_a_data: assert property (@(posedge clk) disable iff (!rst_n)
    (rise && running && pipe_v_q[STAGES])
      |=> shared_sample_bus_o[MSB-1:0] == $past(pipe_a_q[STAGES][MSB-1:0]))
    else $error("first channel word not presented on rise");

  a_chan_b_data: assert property (@(posedge clk) disable iff (!rst_n)
    (fall && running && hold_bv_q)
      |=> shared_sample_bus_o[MSB-1:0] == $past(hold_b_q[MSB-1:0]))
    else $error("second channel word not presented on fall");

  a_msb_code: assert property (@(posedge clk) disable iff (!rst_n)
    (rise && running && pipe_v_q[STAGES])
      |=> shared_sample_bus_o[MSB] == ($past(pipe_a_q[STAGES][MSB]) ^ $past(ctrl.fmt_twos)))
    else $error("output coding msb wrong");

  a_pd_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (halted && $past(halted)) |-> ($stable(shared_sample_bus_o) && $stable(chan_ind)))
    else $error("outputs changed during power-down");

  a_sleep_flush: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.sleep |=> (pipe_v_q == '0 && !primed_q))
    else $error("pipeline still valid in sleep");

  a_latency: assert property (@(posedge clk) disable iff (!rst_n)
    (rise && running && pipe_v_q[STAGES]) |-> rise_cnt_q >= 4'(LATENCY_CYCLES))
    else $error("first word earlier than five converter cycles");

  a_sample_take: assert property (@(posedge clk) disable iff (!rst_n)
    (rise && running) |=> (pipe_v_q[0] && pipe_a_q[0] == $past(first_channel)
                           && pipe_b_q[0] == $past(second_channel)))
    else $error("channels not sampled together on rise");

  //////////////////////////////////////////////////////////////////////////////

  // Mode and phase invariants of the pipeline and output stage
  a_pd_flush: assert property (@(posedge clk) disable iff (!rst_n)
    halted
      |=> (pipe_v_q == '0))
    else $error("pipeline still valid in power-down");

  a_b_ind: assert property (@(posedge clk) disable iff (!rst_n)
    (fall && running && hold_bv_q)
      |=> !chan_ind)
    else $error("indicator high with second channel word");

  a_a_ind: assert property (@(posedge clk) disable iff (!rst_n)
    (rise && running && pipe_v_q[STAGES])
      |=> chan_ind)
    else $error("indicator low with first channel word");

  a_bus_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (!rise && !fall)
      |=> $stable(shared_sample_bus_o))
    else $error("bus changed away from a converter clock edge");

  a_ind_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (!rise && !fall)
      |=> $stable(chan_ind))
    else $error("indicator changed away from a converter clock edge");

  a_pipe_flow: assert property (@(posedge clk) disable iff (!rst_n)
    ((rise || fall) && running)
      |=> (pipe_v_q[STAGES] == $past(pipe_v_q[STAGES-1])))
    else $error("pipeline did not advance one stage");

  a_fall_empty: assert property (@(posedge clk) disable iff (!rst_n)
    (fall && running)
      |=> !pipe_v_q[0])
    else $error("sample taken on a falling edge");

  a_hold_b: assert property (@(posedge clk) disable iff (!rst_n)
    (rise && running && pipe_v_q[STAGES])
      |=> (hold_bv_q && hold_b_q == $past(pipe_b_q[STAGES])))
    else $error("second channel word not held for the fall");

  a_pd_float: assert property (@(posedge clk) disable iff (!rst_n)
    (halted && ctrl.out_dis_n)
      |=> !shared_sample_bus_oe)
    else $error("bus still driven with output disabled in power-down");

  a_sleep_still: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl.sleep && !halted)
      |=> $stable(shared_sample_bus_o))
    else $error("bus changed during sleep");

  a_primed_rise: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(primed_q)
      |-> $past(rise && pipe_v_q[STAGES]))
    else $error("primed set without a first channel word");

  a_idle_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!rise && !fall && running)
      |=> (pipe_v_q == $past(pipe_v_q)))
    else $error("pipeline moved without a converter clock edge");

  a_pd_ind: assert property (@(posedge clk) disable iff (!rst_n)
    (halted && (rise || fall))
      |=> $stable(chan_ind))
    else $error("indicator toggled in power-down");

  a_sleep_hold: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl.sleep
      |=> !hold_bv_q)
    else $error("second channel word pending in sleep");

endmodule

// [dmo_capture.sv]
// Capture logic model taking multiplexed sample words off the shared bus
`timescale 1ns/1ps
module dmo_capture
  import dmo_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                conv_clk,
  input  wire logic                flush,
  input  wire logic [SAMPLE_W-1:0] bus_o,
  input  wire logic                bus_oe,
  input  wire logic                chan_ind,
  output logic                     got_a,
  output logic                     got_b,
  output logic [SAMPLE_W-1:0]      word,
  output logic                     ind
);
  logic       cc_q;
  logic [3:0] cnt_q;
  logic       ok;

  // Words before the pipeline refills are dropped
  assign ok = !flush && (bus_oe === 1'b1) && (cnt_q >= LATENCY_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    cc_q  <= conv_clk;
    got_a <= 1'b0;
    got_b <= 1'b0;
    if (flush) begin
      cnt_q <= 4'h0;
    end else if (conv_clk && !cc_q && cnt_q < 4'hF) begin
      cnt_q <= cnt_q + 4'h1;
    end
    // First word late in high phase, second late in low phase
    if (ok && cc_q && !conv_clk) begin
      got_a <= 1'b1;
      word  <= bus_o;
      ind   <= chan_ind;
    end
    if (ok && !cc_q && conv_clk) begin
      got_b <= 1'b1;
      word  <= bus_o;
      ind   <= chan_ind;
    end
  end
endmodule

// [dmo_core_test.sv]
// Self-checking bench for the multiplexed converter output block
`timescale 1ns/1ps
module dmo_core_test
  import dmo_pkg::*;
;
  localparam int LIMIT = 5000;
  logic                clk;
  logic                reset_n;
  logic                conv_clk;
  logic [SAMPLE_W-1:0] first_channel;
  logic [SAMPLE_W-1:0] second_channel;
  logic                hsel;
  logic [ADDR_W-1:0]   haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [2:0]          hsize;
  logic [31:0]         hwdata;
  logic [31:0]         hrdata;
  logic                hreadyout;
  logic                hresp;
  logic [SAMPLE_W-1:0] shared_sample_bus_o;
  logic                shared_sample_bus_oe;
  logic                chan_ind;
  logic                flush;
  logic                got_a;
  logic                got_b;
  logic [SAMPLE_W-1:0] word;
  logic                ind;
  logic                fm;
  logic [31:0]         rdat;
  logic [SAMPLE_W-1:0] hold_b;
  logic                hold_i;
  logic [SAMPLE_W-1:0] a_q[$];
  logic [SAMPLE_W-1:0] b_q[$];
  logic [SAMPLE_W-1:0] tbl [8] = '{10'h001, 10'h200, 10'h3FF, 10'h155,
                                   10'h2AA, 10'h100, 10'h0FE, 10'h37C};
  int                  fail_count = 0;
  int                  n_compared = 0;
  int                  n_a;
  int                  n_b;
  int                  cyc = 0;

  dmo_core dut (
    .clk(clk), .reset_n(reset_n), .conv_clk(conv_clk),
    .first_channel(first_channel), .second_channel(second_channel),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .shared_sample_bus_o(shared_sample_bus_o),
    .shared_sample_bus_oe(shared_sample_bus_oe), .chan_ind(chan_ind)
  );

  dmo_capture cap (
    .clk(clk), .conv_clk(conv_clk), .flush(flush), .bus_o(shared_sample_bus_o),
    .bus_oe(shared_sample_bus_oe), .chan_ind(chan_ind), .got_a(got_a),
    .got_b(got_b), .word(word), .ind(ind)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Single word transfer, entered just after a rising edge
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rdat = hrdata;
  endtask

  // One converter period, four system clocks per phase
  task automatic conv_cycle(input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
    conv_clk       <= 1'b1;
    first_channel  <= a;
    second_channel <= b;
    a_q.push_back(a);
    b_q.push_back(b);
    repeat (4) @(posedge clk);
    conv_clk <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic stream(input int n, input int base);
    flush <= 1'b0;
    a_q.delete();
    b_q.delete();
    n_a = 0;
    n_b = 0;
    for (int i = 0; i < n; i++) conv_cycle(tbl[(i + base) % 8], tbl[(i + base + 3) % 8]);
    flush <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      wrap_up();
    end
  end

  // Words compared in order; two's complement flips only the MSB
  always @(posedge clk) begin
    if (got_a === 1'b1) begin
      check(word, a_q[0] ^ {fm, 9'h000});
      check(ind, 1'b1);
      void'(a_q.pop_front());
      n_a++;
    end
    if (got_b === 1'b1) begin
      check(word, b_q[0] ^ {fm, 9'h000});
      check(ind, 1'b0);
      void'(b_q.pop_front());
      n_b++;
    end
  end

  initial begin
    reset_n = 1'b0; conv_clk = 1'b0; first_channel = '0; second_channel = '0;
    hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h0;
    hwdata = '0; flush = 1'b1; fm = 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    ahb(CTRL_OFFSET, 1'b0, 32'h0);
    check(rdat, 32'h0000_0008);
    check(hresp, 1'b0);
    check(shared_sample_bus_oe, 1'b0);
    ahb(8'h08, 1'b1, 32'h0000_000F);
    ahb(8'h08, 1'b0, 32'h0);
    check(rdat, 32'h0);
    ahb(CTRL_OFFSET, 1'b1, 32'h0);
    repeat (2) @(posedge clk);
    check(shared_sample_bus_oe, 1'b1);
    stream(12, 0);
    check(n_a, 7);
    check(n_b, 6);
    ahb(STATUS_OFFSET, 1'b0, 32'h0);
    check(rdat[STAT_RUNNING_BIT], 1'b1);
    check(rdat[STAT_PRIMED_BIT], 1'b1);
    check(rdat[STAT_BUS_EN_BIT], 1'b1);
    ahb(CTRL_OFFSET, 1'b1, 32'h2);
    repeat (3) conv_cycle(10'h0AA, 10'h355);
    ahb(STATUS_OFFSET, 1'b0, 32'h0);
    check(rdat[STAT_RUNNING_BIT], 1'b0);
    check(rdat[STAT_PRIMED_BIT], 1'b0);
    fm = 1'b1;
    ahb(CTRL_OFFSET, 1'b1, 32'h1);
    stream(12, 3);
    check(n_a, 7);
    ahb(CTRL_OFFSET, 1'b1, 32'h5);
    repeat (2) @(posedge clk);
    hold_b = shared_sample_bus_o;
    hold_i = chan_ind;
    repeat (3) conv_cycle(10'h111, 10'h222);
    conv_clk <= 1'b1;
    repeat (3) @(posedge clk);
    check(shared_sample_bus_o, hold_b);
    check(chan_ind, hold_i);
    conv_clk <= 1'b0;
    repeat (3) @(posedge clk);
    check(shared_sample_bus_oe, 1'b1);
    ahb(CTRL_OFFSET, 1'b1, 32'hD);
    repeat (2) @(posedge clk);
    check(shared_sample_bus_oe, 1'b0);
    fm = 1'b0;
    ahb(CTRL_OFFSET, 1'b1, 32'h0);
    stream(8, 5);
    check(n_a, 3);
    wrap_up();
  end
endmodule
